/* dv/cca_src_model.sv */
// Count source model standing in for the line input
`timescale 1ns/1ps
module cca_src_model (
    // Clock
    input wire logic clk_sys,
    // Control
    input wire logic run,
    input wire logic [7:0] half,
    // Source pin
    output logic pin
);
    // --------------------------------
    // Square wave, still and low when idle
    // --------------------------------
    logic [7:0] cnt = 8'h00;
    initial pin = 1'b0;
    always @(posedge clk_sys) begin
        if (!run) begin
            pin <= 1'b0;
            cnt <= 8'h00;
        end else if (cnt == half - 8'h01) begin
            pin <= ~pin;
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule // cca_src_model

/* dv/cca_top_assertions.sv */
// Port checker for the calendar clock with alarm
`timescale 1ns/1ps
module cca_top_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Watched ports
    input wire cca_pkg::cca_io_req_t io_req,
    input wire logic [7:0] io_rdata,
    input wire logic crystal_out_pin,
    input wire logic alarm_irq
);
    // --------------------------------
    // Helper logic
    // --------------------------------
    logic [4:0] src_age;
    logic rd_ctl;
    logic fw;
    logic fw_noint;
    assign rd_ctl = io_req.rd && io_req.addr == cca_pkg::OFS_CONTROL;
    assign fw = io_req.wr && io_req.addr == cca_pkg::OFS_CONTROL && !io_req.wdata[0];
    assign fw_noint = fw && !io_req.wdata[6];
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            src_age <= 5'h1F;
        end else if (crystal_out_pin) begin
            src_age <= 5'h00;
        end else if (src_age != 5'h1F) begin
            src_age <= src_age + 5'h01;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // --------------------------------
    // Assertions
    // --------------------------------
    a_reset_quiet: assert property ($rose(rst_n) |-> io_rdata == 8'h00 && !alarm_irq)
        else $error("outputs not quiet after reset");
    a_irq_holds: assert property (alarm_irq && !rd_ctl |=> alarm_irq)
        else $error("irq dropped without control read");
    a_read_clears: assert property (rd_ctl && src_age == 5'h1F |=> !alarm_irq)
        else $error("irq kept after control read");
    a_irq_cause: assert property ($rose(alarm_irq) |->
        $past(fw, 2) || $past(fw, 3) || src_age < 5'h10)
        else $error("irq rose with no compare");
    a_no_int: assert property (fw_noint |=> !$rose(alarm_irq) [*3])
        else $error("irq rose with interrupt off");
    a_weekday_upper: assert property (io_req.rd && io_req.addr == cca_pkg::OFS_WEEKDAY
        |=> io_rdata[7:4] == 4'h0)
        else $error("weekday upper bits set");
    a_sec_range: assert property (io_req.rd && io_req.addr == cca_pkg::OFS_SECONDS
        |=> io_rdata <= 8'h59)
        else $error("seconds out of range");
    a_min_range: assert property (io_req.rd && io_req.addr == cca_pkg::OFS_MINUTES
        |=> io_rdata <= 8'h59)
        else $error("minutes out of range");
    a_hrs_range: assert property (io_req.rd && io_req.addr == cca_pkg::OFS_HOURS
        |=> io_rdata <= 8'h23)
        else $error("hours out of range");
    c_irq_rise: cover property ($rose(alarm_irq));
    c_irq_read: cover property (rd_ctl && alarm_irq);
    c_forced: cover property (fw ##2 alarm_irq);
endmodule // cca_top_checker
bind cca_top cca_top_checker cca_top_checker_i (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .io_req(io_req),
    .io_rdata(io_rdata),
    .crystal_out_pin(crystal_out_pin),
    .alarm_irq(alarm_irq)
);

/* dv/tb.sv */
// Testbench of the calendar clock with alarm
`timescale 1ns/1ps
module tb;
    // --------------------------------
    // Signals and instances
    // --------------------------------
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    cca_pkg::cca_io_req_t io_req = '0;
    logic [7:0] io_rdata;
    logic crystal_out_pin;
    logic alarm_irq;
    logic src_run = 1'b0;
    logic [7:0] src_half = 8'h02;
    logic taken = 1'b0;
    logic [7:0] r;
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;
    int i;
    logic [7:0] exp_q[$];
    logic [7:0] adr_q[$];
    logic [7:0] tset [8] = '{8'h3B, 8'h3B, 8'h17, 8'hF7, 8'h1C, 8'h02, 8'h01, 8'h14};
    logic [7:0] tnext [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h01, 8'h14};
    always #10 clk_sys = ~clk_sys;
    cca_top cca_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .io_req(io_req),
        .io_rdata(io_rdata), .crystal_out_pin(crystal_out_pin), .alarm_irq(alarm_irq));
    cca_src_model cca_src_model_i (.clk_sys(clk_sys), .run(src_run), .half(src_half),
        .pin(crystal_out_pin));
    // --------------------------------
    // Tasks
    // --------------------------------
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        io_req = {1'b0, 1'b1, a, d};
        @(negedge clk_sys);
        io_req = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        exp_q.push_back(e);
        adr_q.push_back(a);
        io_req = {1'b1, 1'b0, a, 8'h00};
        @(negedge clk_sys);
        io_req = '0;
    endtask
    task automatic run_src(input int e);
        int n;
        n = 0;
        @(negedge clk_sys);
        src_run = 1'b1;
        while (alarm_irq !== 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        src_run = 1'b0;
        chk("second length", 8'h01, {7'h00, n >= 4 * e && n <= 4 * e + 12});
    endtask
    task automatic tdone(input string s);
        $display("test %s done", s);
    endtask
    task final_report;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // --------------------------------
    // Read monitor and timeout
    // --------------------------------
    always @(posedge clk_sys) taken <= io_req.rd;
    always @(negedge clk_sys) begin
        if (taken) begin
            chk($sformatf("read %h", adr_q[0]), exp_q.pop_front(), io_rdata);
            void'(adr_q.pop_front());
        end
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 4000) begin
            num_errors++;
            $display("unexpected timeout expected done seen hang");
            final_report();
        end
    end
    // --------------------------------
    // Main sequence
    // --------------------------------
    initial begin
        void'($urandom(32'h0000_029a));
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        rd(cca_pkg::OFS_CONTROL, cca_pkg::RST_CONTROL);
        rd(cca_pkg::OFS_ALM_ENABLE, 8'h00);
        chk("irq", 8'h00, {7'h00, alarm_irq});
        tdone("reset");
        wr(cca_pkg::OFS_CONTROL, 8'h19);
        repeat (3) begin
            r = 8'($urandom_range(59));
            wr(cca_pkg::OFS_SECONDS, r);
            rd(cca_pkg::OFS_SECONDS, r);
        end
        for (i = 0; i < 8; i++) wr(cca_pkg::OFS_SECONDS + 8'(i), tset[i]);
        rd(cca_pkg::OFS_WEEKDAY, 8'h07);
        wr(cca_pkg::OFS_ALM_SECONDS, 8'h00);
        wr(cca_pkg::OFS_ALM_ENABLE, 8'h01);
        wr(cca_pkg::OFS_CONTROL, 8'h58);
        wr(cca_pkg::OFS_SECONDS, 8'h00);
        rd(cca_pkg::OFS_SECONDS, 8'h3B);
        tdone("setup");
        run_src(50);
        for (i = 0; i < 8; i++) rd(cca_pkg::OFS_SECONDS + 8'(i), tnext[i]);
        rd(cca_pkg::OFS_CONTROL, 8'hD8);
        chk("irq", 8'h00, {7'h00, alarm_irq});
        tdone("rollover");
        wr(cca_pkg::OFS_ALM_SECONDS, 8'h01);
        wr(cca_pkg::OFS_CONTROL, 8'h50);
        run_src(60);
        rd(cca_pkg::OFS_SECONDS, 8'h01);
        rd(cca_pkg::OFS_CONTROL, 8'hD0);
        tdone("line60");
        wr(cca_pkg::OFS_CONTROL, 8'h50);
        repeat (2) @(negedge clk_sys);
        chk("irq", 8'h01, {7'h00, alarm_irq});
        rd(cca_pkg::OFS_CONTROL, 8'hD0);
        wr(cca_pkg::OFS_CONTROL, 8'h10);
        repeat (2) @(negedge clk_sys);
        chk("irq", 8'h00, {7'h00, alarm_irq});
        rd(cca_pkg::OFS_CONTROL, 8'h90);
        wr(cca_pkg::OFS_ALM_MINUTES, 8'h05);
        wr(cca_pkg::OFS_ALM_ENABLE, 8'h03);
        wr(cca_pkg::OFS_CONTROL, 8'h10);
        repeat (2) @(negedge clk_sys);
        rd(cca_pkg::OFS_CONTROL, 8'h10);
        tdone("forced");
        rst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        rd(cca_pkg::OFS_CONTROL, 8'h00);
        rd(cca_pkg::OFS_ALM_ENABLE, 8'h00);
        rd(cca_pkg::OFS_SECONDS, 8'h01);
        repeat (2) @(negedge clk_sys);
        tdone("rereset");
        wr(cca_pkg::OFS_CONTROL, 8'h31);
        wr(cca_pkg::OFS_SECONDS, 8'h59);
        wr(cca_pkg::OFS_MINUTES, 8'h59);
        wr(cca_pkg::OFS_HOURS, 8'h23);
        wr(cca_pkg::OFS_MONTHDAY, 8'h29);
        wr(cca_pkg::OFS_MONTH, 8'h02);
        wr(cca_pkg::OFS_YEAR, 8'h00);
        wr(cca_pkg::OFS_CENTURY, 8'h20);
        wr(cca_pkg::OFS_ALM_SECONDS, 8'h00);
        wr(cca_pkg::OFS_ALM_ENABLE, 8'h01);
        wr(cca_pkg::OFS_CONTROL, 8'h70);
        run_src(60);
        rd(cca_pkg::OFS_SECONDS, 8'h00);
        rd(cca_pkg::OFS_MINUTES, 8'h00);
        rd(cca_pkg::OFS_HOURS, 8'h00);
        rd(cca_pkg::OFS_MONTHDAY, 8'h01);
        rd(cca_pkg::OFS_MONTH, 8'h03);
        rd(cca_pkg::OFS_CONTROL, 8'hF0);
        tdone("bcd");
        final_report();
    end
endmodule // tb

/* inc/cca_pkg.sv */
// Package of constants and types for the calendar clock with alarm
package cca_pkg;

    // ------------------------------------------------------------
    // Register offsets on the I/O bus
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SECONDS = 8'h00_E0;
    localparam logic [7:0] OFS_MINUTES = 8'h00_E1;
    localparam logic [7:0] OFS_HOURS = 8'h00_E2;
    localparam logic [7:0] OFS_WEEKDAY = 8'h00_E3;
    localparam logic [7:0] OFS_MONTHDAY = 8'h00_E4;
    localparam logic [7:0] OFS_MONTH = 8'h00_E5;
    localparam logic [7:0] OFS_YEAR = 8'h00_E6;
    localparam logic [7:0] OFS_CENTURY = 8'h00_E7;
    localparam logic [7:0] OFS_ALM_SECONDS = 8'h00_E8;
    localparam logic [7:0] OFS_ALM_MINUTES = 8'h00_E9;
    localparam logic [7:0] OFS_ALM_HOURS = 8'h00_EA;
    localparam logic [7:0] OFS_ALM_WEEKDAY = 8'h00_EB;
    localparam logic [7:0] OFS_ALM_ENABLE = 8'h00_EC;
    localparam logic [7:0] OFS_CONTROL = 8'h00_ED;

    // ------------------------------------------------------------
    // Control register bit positions
    // ------------------------------------------------------------
    localparam int CTL_UNLOCK_BIT = 0;
    localparam int CTL_LINE50_BIT = 3;
    localparam int CTL_CLKSEL_BIT = 4;
    localparam int CTL_BCD_BIT = 5;
    localparam int CTL_INTEN_BIT = 6;
    localparam int CTL_ALARM_BIT = 7;

    // Alarm enable bit positions
    localparam int AEN_SEC_BIT = 0;
    localparam int AEN_MIN_BIT = 1;
    localparam int AEN_HRS_BIT = 2;
    localparam int AEN_DOW_BIT = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL = 8'h00_00;
    localparam logic [3:0] RST_ALM_ENABLE = 4'h0;
    localparam logic [7:0] RST_RDATA = 8'h00_00;

    // ------------------------------------------------------------
    // Count limits, binary form
    // ------------------------------------------------------------
    localparam logic [7:0] SEC_MAX = 8'h00_3B;
    localparam logic [7:0] MIN_MAX = 8'h00_3B;
    localparam logic [7:0] HRS_MAX = 8'h00_17;
    localparam logic [7:0] DOW_MIN = 8'h00_01;
    localparam logic [7:0] DOW_MAX = 8'h00_07;
    localparam logic [7:0] DOM_MIN = 8'h00_01;
    localparam logic [7:0] MON_MIN = 8'h00_01;
    localparam logic [7:0] MON_MAX = 8'h00_0C;
    localparam logic [7:0] YR_MAX = 8'h00_63;
    localparam logic [7:0] CEN_MAX = 8'h00_63;

    // ------------------------------------------------------------
    // Source edges per second
    // ------------------------------------------------------------
    localparam logic [15:0] XTAL_EDGES_PER_SEC = 16'h8000;
    localparam logic [15:0] LINE50_EDGES_PER_SEC = 16'h0032;
    localparam logic [15:0] LINE60_EDGES_PER_SEC = 16'h003C;

    // ------------------------------------------------------------
    // Bus request carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cca_io_req_t;

    // Prescaler state
    typedef struct packed {
        logic [15:0] edges;
        logic src_prev;
        logic tick;
    } cca_pre_state_t;

    // Main block state
    typedef struct packed {
        logic [7:0] seconds_count;
        logic [7:0] minutes_count;
        logic [7:0] hours_count;
        logic [3:0] weekday_count;
        logic [7:0] monthday_count;
        logic [7:0] month_count;
        logic [7:0] year_count;
        logic [7:0] century_count;
        logic [7:0] alm_seconds;
        logic [7:0] alm_minutes;
        logic [7:0] alm_hours;
        logic [3:0] alm_weekday;
        logic [3:0] alm_enable;
        logic unlock;
        logic line50;
        logic clk_sel;
        logic bcd_en;
        logic int_en;
        logic alarm_flag;
        logic alarm_irq;
        logic cmp_req;
        logic [7:0] rdata;
    } cca_state_t;

endpackage

/* rtl/cca_prescaler.sv */
// Divider from the count source down to one pulse per second
`timescale 1ns/1ps
module cca_prescaler (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Source and control
    input wire logic src_level,
    input wire logic clr,
    input wire logic run,
    input wire logic [15:0] edges_per_sec,
    // Output
    output logic sec_tick
);

    cca_pkg::cca_pre_state_t st;
    cca_pkg::cca_pre_state_t next_st;

    // ------------------------------------------------------------
    // Edge counting
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.src_prev = src_level;
        next_st.tick = 1'b0;
        if (clr || !run) begin
            next_st.edges = 16'h0000;
        end else if (src_level && !st.src_prev) begin
            if (st.edges == 16'(edges_per_sec - 16'h0001)) begin
                next_st.edges = 16'h0000;
                next_st.tick = 1'b1;
            end else begin
                next_st.edges = 16'(st.edges + 16'h0001);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sec_tick = st.tick;

endmodule // cca_prescaler

/* rtl/cca_top.sv */
// Calendar clock with alarm, register file and count logic
//
// Overview of operation
// [R1] Keep seconds to century counts, hours in 24-hour form.
// [R2] One format bit switches all count and alarm registers binary or BCD.
// [R3] Day of month rolls by month length, leap years handled.
// [R4] Alarm fires only when every enabled set-point equals its count.
// [R5] Alarm sets the flag; interrupt raised only if interrupt enable set.
// [R6] Reading control clears alarm flag and pending interrupt.
// [R7] Alarm set-points and enables writable whether locked or not.
// [R8] Alarm compared each time the count advances, once a second.
// [R9] Writing unlock as 0 forces an alarm comparison.
// [R10] Source is crystal or 50/60 Hz line; divider follows selection.
// [R11] Every control write resets the divider.
// [R12] After reset counts undefined and all alarm enables cleared.
// [R13] Host unlocks, sets time, sets alarms, then locks.
// [R14] Clearing unlock resets then enables the divider.
// [R15] Unlocked halts counting and opens count writes; locked ignores them.
// [R16] Reset leaves the clock locked.
// [R17] Count registers keep contents through reset.
// [R18] Seconds: BCD tens 0-5 in [7:4], ones 0-9; binary 0 to 3Bh.
// [R19] Minutes: BCD tens 0-5, ones 0-9; binary 0 to 3Bh.
// [R20] Hours: BCD tens 0-2, ones 0-9; binary 0 to 17h.
// [R21] Weekday in low four bits from 01h; upper bits read zero.
// [R22] Day of month 01h to 1Fh, month 01h to 0Ch.
// [R23] Year and century 00h to 63h binary, digits 0-9 in BCD.
// [R24] Divider gives one pulse a second, carried up through the calendar.
`timescale 1ns/1ps
module cca_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // I/O bus
    input wire cca_pkg::cca_io_req_t io_req,
    output logic [7:0] io_rdata,
    // Count source
    input wire logic crystal_out_pin,
    // Interrupt
    output logic alarm_irq
);

    cca_pkg::cca_state_t st;
    cca_pkg::cca_state_t next_st;
    logic sec_tick;
    logic ctl_wr;
    logic [15:0] edges_per_sec;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic logic [7:0] to_bcd(input logic [7:0] b);
        logic [7:0] t;
        logic [7:0] o;
        t = b / 8'h0A;
        o = b % 8'h0A;
        return {t[3:0], o[3:0]};
    endfunction

    function automatic logic [7:0] from_bcd(input logic [7:0] v);
        return 8'({4'h0, v[7:4]} * 8'h0A + {4'h0, v[3:0]});
    endfunction

    // Returns {carry, next value}
    function automatic logic [8:0] bump(input logic [7:0] val, input logic [7:0] lo,
                                        input logic [7:0] hi, input logic bcd);
        logic [7:0] hi_f;
        logic [7:0] lo_f;
        hi_f = bcd ? to_bcd(hi) : hi;
        lo_f = bcd ? to_bcd(lo) : lo;
        if (val == hi_f) begin
            return {1'b1, lo_f};
        end else if (bcd && val[3:0] == 4'h9) begin
            return {1'b0, 4'(val[7:4] + 4'h1), 4'h0};
        end else begin
            return {1'b0, 8'(val + 8'h01)};
        end
    endfunction

    function automatic logic [7:0] month_len(input logic [7:0] mon, input logic leap);
        case (mon)
            8'h02: month_len = leap ? 8'h1D : 8'h1C;
            8'h04, 8'h06, 8'h09, 8'h0B: month_len = 8'h1E;
            default: month_len = 8'h1F;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    assign ctl_wr = io_req.wr && io_req.addr == cca_pkg::OFS_CONTROL;

    always_comb begin
        if (!st.clk_sel) begin
            edges_per_sec = cca_pkg::XTAL_EDGES_PER_SEC; // R10
        end else if (st.line50) begin
            edges_per_sec = cca_pkg::LINE50_EDGES_PER_SEC; // R10
        end else begin
            edges_per_sec = cca_pkg::LINE60_EDGES_PER_SEC; // R10
        end
    end

    cca_prescaler u_prescaler (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .src_level(crystal_out_pin),
        .clr(ctl_wr), // R11 R14
        .run(!st.unlock), // R15 R14
        .edges_per_sec(edges_per_sec),
        .sec_tick(sec_tick) // R24
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic [8:0] r_sec;
    logic [8:0] r_min;
    logic [8:0] r_hrs;
    logic [8:0] r_dow;
    logic [8:0] r_dom;
    logic [8:0] r_mon;
    logic [8:0] r_yr;
    logic [8:0] r_cen;
    logic [7:0] yr_b;
    logic [7:0] cen_b;
    logic leap;
    logic hit;
    logic [7:0] rd_mux;

    always_comb begin
        next_st = st;
        next_st.cmp_req = 1'b0;
        yr_b = st.bcd_en ? from_bcd(st.year_count) : st.year_count;
        cen_b = st.bcd_en ? from_bcd(st.century_count) : st.century_count;
        leap = (yr_b[1:0] == 2'b00) && ((yr_b != 8'h00) || (cen_b[1:0] == 2'b00)); // R3
        r_sec = bump(st.seconds_count, 8'h00, cca_pkg::SEC_MAX, st.bcd_en); // R18
        r_min = bump(st.minutes_count, 8'h00, cca_pkg::MIN_MAX, st.bcd_en); // R19
        r_hrs = bump(st.hours_count, 8'h00, cca_pkg::HRS_MAX, st.bcd_en); // R20 R1
        r_dow = bump({4'h0, st.weekday_count}, cca_pkg::DOW_MIN, cca_pkg::DOW_MAX,
                     1'b0); // R21
        r_dom = bump(st.monthday_count, cca_pkg::DOM_MIN,
                     month_len(st.bcd_en ? from_bcd(st.month_count) : st.month_count,
                               leap), st.bcd_en); // R3 R22
        r_mon = bump(st.month_count, cca_pkg::MON_MIN, cca_pkg::MON_MAX, st.bcd_en); // R22
        r_yr = bump(st.year_count, 8'h00, cca_pkg::YR_MAX, st.bcd_en); // R23
        r_cen = bump(st.century_count, 8'h00, cca_pkg::CEN_MAX, st.bcd_en); // R23

        // Once-a-second advance, carried upward
        if (sec_tick && !st.unlock) begin // R24 R15
            next_st.cmp_req = 1'b1; // R8
            next_st.seconds_count = r_sec[7:0]; // R1
            if (r_sec[8]) begin
                next_st.minutes_count = r_min[7:0];
                if (r_min[8]) begin
                    next_st.hours_count = r_hrs[7:0];
                    if (r_hrs[8]) begin
                        next_st.weekday_count = r_dow[3:0];
                        next_st.monthday_count = r_dom[7:0];
                        if (r_dom[8]) begin
                            next_st.month_count = r_mon[7:0];
                            if (r_mon[8]) begin
                                next_st.year_count = r_yr[7:0];
                                if (r_yr[8]) begin
                                    next_st.century_count = r_cen[7:0];
                                end
                            end
                        end
                    end
                end
            end
        end

        // Register writes
        if (io_req.wr) begin
            if (st.unlock) begin // R15
                case (io_req.addr)
                    cca_pkg::OFS_SECONDS: next_st.seconds_count = io_req.wdata;
                    cca_pkg::OFS_MINUTES: next_st.minutes_count = io_req.wdata;
                    cca_pkg::OFS_HOURS: next_st.hours_count = io_req.wdata;
                    cca_pkg::OFS_WEEKDAY: next_st.weekday_count = io_req.wdata[3:0];
                    cca_pkg::OFS_MONTHDAY: next_st.monthday_count = io_req.wdata;
                    cca_pkg::OFS_MONTH: next_st.month_count = io_req.wdata;
                    cca_pkg::OFS_YEAR: next_st.year_count = io_req.wdata;
                    cca_pkg::OFS_CENTURY: next_st.century_count = io_req.wdata;
                    default: ;
                endcase
            end
            case (io_req.addr) // R7
                cca_pkg::OFS_ALM_SECONDS: next_st.alm_seconds = io_req.wdata;
                cca_pkg::OFS_ALM_MINUTES: next_st.alm_minutes = io_req.wdata;
                cca_pkg::OFS_ALM_HOURS: next_st.alm_hours = io_req.wdata;
                cca_pkg::OFS_ALM_WEEKDAY: next_st.alm_weekday = io_req.wdata[3:0];
                cca_pkg::OFS_ALM_ENABLE: next_st.alm_enable = io_req.wdata[3:0];
                cca_pkg::OFS_CONTROL: begin
                    next_st.unlock = io_req.wdata[cca_pkg::CTL_UNLOCK_BIT];
                    next_st.line50 = io_req.wdata[cca_pkg::CTL_LINE50_BIT];
                    next_st.clk_sel = io_req.wdata[cca_pkg::CTL_CLKSEL_BIT]; // R10
                    next_st.bcd_en = io_req.wdata[cca_pkg::CTL_BCD_BIT]; // R2
                    next_st.int_en = io_req.wdata[cca_pkg::CTL_INTEN_BIT];
                    if (!io_req.wdata[cca_pkg::CTL_UNLOCK_BIT]) begin
                        next_st.cmp_req = 1'b1; // R9
                    end
                end
                default: ;
            endcase
        end

        // Alarm comparison, one cycle after its request
        hit = st.cmp_req && (st.alm_enable != 4'h0)
            && (!st.alm_enable[cca_pkg::AEN_SEC_BIT] || st.alm_seconds == st.seconds_count)
            && (!st.alm_enable[cca_pkg::AEN_MIN_BIT] || st.alm_minutes == st.minutes_count)
            && (!st.alm_enable[cca_pkg::AEN_HRS_BIT] || st.alm_hours == st.hours_count)
            && (!st.alm_enable[cca_pkg::AEN_DOW_BIT]
                || st.alm_weekday == st.weekday_count); // R4

        // Read data and read side effect
        case (io_req.addr)
            cca_pkg::OFS_SECONDS: rd_mux = st.seconds_count;
            cca_pkg::OFS_MINUTES: rd_mux = st.minutes_count;
            cca_pkg::OFS_HOURS: rd_mux = st.hours_count;
            cca_pkg::OFS_WEEKDAY: rd_mux = {4'h0, st.weekday_count}; // R21
            cca_pkg::OFS_MONTHDAY: rd_mux = st.monthday_count;
            cca_pkg::OFS_MONTH: rd_mux = st.month_count;
            cca_pkg::OFS_YEAR: rd_mux = st.year_count;
            cca_pkg::OFS_CENTURY: rd_mux = st.century_count;
            cca_pkg::OFS_ALM_SECONDS: rd_mux = st.alm_seconds;
            cca_pkg::OFS_ALM_MINUTES: rd_mux = st.alm_minutes;
            cca_pkg::OFS_ALM_HOURS: rd_mux = st.alm_hours;
            cca_pkg::OFS_ALM_WEEKDAY: rd_mux = {4'h0, st.alm_weekday};
            cca_pkg::OFS_ALM_ENABLE: rd_mux = {4'h0, st.alm_enable};
            cca_pkg::OFS_CONTROL: rd_mux = {st.alarm_flag, st.int_en, st.bcd_en, st.clk_sel,
                                            st.line50, 2'b00, st.unlock};
            default: rd_mux = 8'h00;
        endcase
        if (io_req.rd) begin
            next_st.rdata = rd_mux;
            if (io_req.addr == cca_pkg::OFS_CONTROL) begin
                next_st.alarm_flag = 1'b0; // R6
                next_st.alarm_irq = 1'b0; // R6
            end
        end

        // Set wins over the read clear
        if (hit) begin
            next_st.alarm_flag = 1'b1; // R5
            if (st.int_en) begin
                next_st.alarm_irq = 1'b1; // R5
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st.seconds_count <= st.seconds_count; // R17
            st.minutes_count <= st.minutes_count;
            st.hours_count <= st.hours_count;
            st.weekday_count <= st.weekday_count;
            st.monthday_count <= st.monthday_count;
            st.month_count <= st.month_count;
            st.year_count <= st.year_count;
            st.century_count <= st.century_count;
            st.alm_seconds <= st.alm_seconds;
            st.alm_minutes <= st.alm_minutes;
            st.alm_hours <= st.alm_hours;
            st.alm_weekday <= st.alm_weekday;
            st.alm_enable <= cca_pkg::RST_ALM_ENABLE; // R12
            st.unlock <= cca_pkg::RST_CONTROL[cca_pkg::CTL_UNLOCK_BIT]; // R16
            st.line50 <= cca_pkg::RST_CONTROL[cca_pkg::CTL_LINE50_BIT];
            st.clk_sel <= cca_pkg::RST_CONTROL[cca_pkg::CTL_CLKSEL_BIT];
            st.bcd_en <= cca_pkg::RST_CONTROL[cca_pkg::CTL_BCD_BIT];
            st.int_en <= cca_pkg::RST_CONTROL[cca_pkg::CTL_INTEN_BIT];
            st.alarm_flag <= cca_pkg::RST_CONTROL[cca_pkg::CTL_ALARM_BIT];
            st.alarm_irq <= 1'b0;
            st.cmp_req <= 1'b0;
            st.rdata <= cca_pkg::RST_RDATA;
        end else begin
            st <= next_st;
        end
    end

    assign io_rdata = st.rdata;
    assign alarm_irq = st.alarm_irq;

endmodule // cca_top
